// ==== dwf_front_end.sv ====
// dac waveform fifo front end: register decode, fifo store and point playback
// assumes one-cycle read/write strobes from the pcie endpoint's bar decoder
//
// Summary of operation
// - each data-register write pushes one word unless the fifo is full
// - word: channel in 19:16, code 15:0
// - data-register read returns fill count, no pop
// - dacs-per-point register holds one to four
// - size register reads capacity, 8192 words
// - dma regs in bars 1:0, i/o in 3:2
`timescale 1ns/1ps
module dwf_front_end
   import dwf_pkg::*;
(
   // clock and reset
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   // register port
   input  wire dwf_req_s       req,
   output logic                rd_valid,
   output logic [31:0]         rd_data,
   // playback side
   input  wire logic           point_tick,
   output logic                dac_valid,
   output dwf_cmd_s            dac_cmd,
   output logic                point_done
);
   // ******************************
   // storage and state
   // ******************************
   logic [31:0]       mem [DWF_DEPTH];  // command words
   logic [DWF_AW-1:0] wr_ptr;           // tail index
   logic [DWF_AW-1:0] rd_ptr;           // head index
   logic [DWF_AW:0]   level;            // words held
   logic [2:0]        chan_per_pt;      // programmed dacs per point
   logic [2:0]        sent;             // words sent this point
   dwf_state_e        state;            // playback state
   logic              push;             // accepted write
   logic              pop;              // playback read
   logic              io_hit;           // access inside i/o window

   // ******************************
   // decode
   // ******************************
   // register hits only count in the i/o window; dma window is elsewhere
   // window split
   function automatic logic hit(input dwf_req_s r, input logic [7:0] off);
      hit = (r.win == DWF_WIN_IO[0]) && (r.addr == off);
   endfunction

   assign io_hit = req.win == DWF_WIN_IO[0];
   // full fifo drops the write; host should check level first
   // push on write
   assign push = req.wr && hit(req, DWF_OFF_PUSH_LEVEL)
                 && (level != (DWF_AW+1)'(DWF_DEPTH));
   assign pop  = (state == DWF_POP);

   // ******************************
   // fifo store
   // ******************************
   // upper bits forced to zero so only the documented fields survive
   // word layout
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= {12'h000, req.wdata[DWF_CH_LSB+DWF_CH_W-1:0]};
      end
   end

   // tail pointer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         wr_ptr <= '0;
      else if (push)
         wr_ptr <= wr_ptr + 1'b1;
   end

   // head pointer
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_ptr <= '0;
      else if (pop)
         rd_ptr <= rd_ptr + 1'b1;
   end

   // fill level, push and pop may coincide
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         level <= '0;
      else if (push && !pop)
         level <= level + 1'b1;
      else if (pop && !push)
         level <= level - 1'b1;
   end

   // ******************************
   // configuration register
   // ******************************
   // values outside one..four are ignored so playback never stalls
   // dacs per point
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         chan_per_pt <= DWF_CPP_RESET;
      else if (req.wr && hit(req, DWF_OFF_CHAN_PER_PT) && req.wdata[31:3] == 29'h0
               && req.wdata[2:0] != 3'h0 && req.wdata[2:0] <= DWF_CPP_MAX)
         chan_per_pt <= req.wdata[2:0];
   end

   // ******************************
   // read path
   // ******************************
   // one-cycle read answer; unmapped offsets read zero
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_valid <= 1'b0;
         rd_data  <= 32'h0000_0000;
      end
      else
      begin
         rd_valid <= req.rd;
         rd_data  <= 32'h0000_0000;
         if (req.rd && io_hit)
         begin
            case (req.addr)
               DWF_OFF_PUSH_LEVEL:  rd_data <= {{(31-DWF_AW){1'b0}}, level};
               DWF_OFF_CHAN_PER_PT: rd_data <= {29'h0, chan_per_pt};
               DWF_OFF_CAPACITY:    rd_data <= DWF_CAPACITY;
               default:             rd_data <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ******************************
   // playback
   // ******************************
   // a point starts only with a full set held, so channels never split
   // in-order point pops
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= DWF_IDLE;
         sent  <= 3'h0;
      end
      else
      begin
         case (state)
            DWF_IDLE:
            begin
               sent <= 3'h0;
               if (point_tick && level >= {{(DWF_AW-2){1'b0}}, chan_per_pt})
                  state <= DWF_POP;
            end
            DWF_POP:
            begin
               sent  <= sent + 1'b1;
               state <= DWF_SEND;
            end
            DWF_SEND:
               state <= (sent == chan_per_pt) ? DWF_IDLE : DWF_POP;
            default:
               state <= DWF_IDLE;
         endcase
      end
   end

   // word toward the dacs, one cycle after its pop
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dac_valid  <= 1'b0;
         dac_cmd    <= '0;
         point_done <= 1'b0;
      end
      else
      begin
         dac_valid  <= pop;
         point_done <= pop && (sent + 3'h1 == chan_per_pt);
         if (pop)
            dac_cmd <= mem[rd_ptr][DWF_CH_LSB+DWF_CH_W-1:0];
      end
   end

   // ******************************
   // checks
   // ******************************
   sequence s_pop_then_out;
      pop ##1 dac_valid;
   endsequence

   a_read_level: assert property (@(posedge core_clk) disable iff (!rst_n)
      req.rd && hit(req, DWF_OFF_PUSH_LEVEL) |=> rd_valid && rd_data == 32'($past(level)))
      else $error("level read wrong");
   a_read_size: assert property (@(posedge core_clk) disable iff (!rst_n)
      req.rd && hit(req, DWF_OFF_CAPACITY) |=> rd_data == 32'h0000_2000)
      else $error("size read wrong");
   a_push_count: assert property (@(posedge core_clk) disable iff (!rst_n)
      push && !pop |=> level == $past(level) + 1'b1)
      else $error("push not counted");
   a_read_nopop: assert property (@(posedge core_clk) disable iff (!rst_n)
      req.rd && !push && !pop |=> level == $past(level))
      else $error("read changed level");
   a_cpp_range: assert property (@(posedge core_clk) disable iff (!rst_n)
      chan_per_pt != 3'h0 && chan_per_pt <= 3'h4)
      else $error("dacs per point out of range");
   a_cmd_field: assert property (@(posedge core_clk) disable iff (!rst_n)
      push |=> mem[$past(wr_ptr)] == {12'h000, $past(req.wdata[DWF_CH_LSB+DWF_CH_W-1:0])})
      else $error("stored word wrong");
   a_pop_out: assert property (@(posedge core_clk) disable iff (!rst_n)
      pop |-> s_pop_then_out)
      else $error("popped word not sent");
   a_point_len: assert property (@(posedge core_clk) disable iff (!rst_n)
      point_done |-> $past(sent) + 3'h1 == chan_per_pt)
      else $error("point length wrong");
   a_dma_window: assert property (@(posedge core_clk) disable iff (!rst_n)
      req.wr && req.win == 1'b0 |-> !push)
      else $error("dma window pushed fifo");
endmodule

// ==== dwf_host_model.sv ====
// host-side register master for the dac waveform fifo front end
// assumes one-cycle strobes and read data one cycle after the read edge
`timescale 1ns/1ps
module dwf_host_model
   import dwf_pkg::*;
(
   // clock
   input  wire logic        core_clk,
   // answer from the device
   input  wire logic        rd_valid,
   input  wire logic [31:0] rd_data,
   // request to the device
   output dwf_req_s         req
);
   initial req = '0;
   // ******************************
   // bus cycles
   // ******************************
   // full words, i/o window
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      wrw(1'b1, a, wd);
   endtask
   task automatic wrw(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk);
      req <= '{w, 1'b1, 1'b0, a, wd};
      @(posedge core_clk);
      // released data must not look valid
      req <= '{w, 1'b0, 1'b0, a, ~wd};
   endtask
   // read strobe, answer one edge later
   task automatic rd(input logic w, input logic [7:0] a,
                     output logic v, output logic [31:0] rv);
      @(posedge core_clk);
      req <= '{w, 1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk);
      req.rd <= 1'b0;
      @(posedge core_clk);
      v  = rd_valid;
      rv = rd_data;
   endtask
endmodule

// ==== dwf_pkg.sv ====
// package for the dac waveform fifo front end: offsets, field layout, sizes
// assumes a 32-bit register port decoded from the i/o register window
package dwf_pkg;
   // ******************************
   // register map
   // ******************************
   localparam logic [7:0]  DWF_OFF_PUSH_LEVEL = 8'h50;  // fifo data / level
   localparam logic [7:0]  DWF_OFF_CHAN_PER_PT = 8'h54; // dacs per point
   localparam logic [7:0]  DWF_OFF_CAPACITY   = 8'h58;  // fifo size
   // ******************************
   // window selection
   // ******************************
   localparam logic [1:0]  DWF_WIN_DMA = 2'h0;          // bars 1:0
   localparam logic [1:0]  DWF_WIN_IO  = 2'h1;          // bars 3:2
   // ******************************
   // fifo geometry and fields
   // ******************************
   localparam int          DWF_DEPTH     = 8192;        // command words
   localparam int          DWF_AW        = 13;          // index width
   localparam logic [31:0] DWF_CAPACITY  = 32'h0000_2000;
   localparam int          DWF_CH_LSB    = 16;          // channel field low bit
   localparam int          DWF_CH_W      = 4;           // channel field width
   localparam int          DWF_CODE_W    = 16;          // output code width
   localparam logic [2:0]  DWF_CPP_RESET = 3'h1;        // one dac per point
   localparam logic [2:0]  DWF_CPP_MAX   = 3'h4;        // most dacs per point
   // register access carrier
   typedef struct packed
   {
      logic        win;     // window: 1 = i/o registers
      logic        wr;      // write strobe
      logic        rd;      // read strobe
      logic [7:0]  addr;    // byte offset in window
      logic [31:0] wdata;   // write data
   } dwf_req_s;
   // one decoded command word
   typedef struct packed
   {
      logic [DWF_CH_W-1:0]   chan;  // target dac
      logic [DWF_CODE_W-1:0] code;  // output counts
   } dwf_cmd_s;
   typedef enum logic [1:0]
   {
      DWF_IDLE = 2'b00,
      DWF_POP  = 2'b01,
      DWF_SEND = 2'b10
   } dwf_state_e;
endpackage

// ==== test_dwf_front_end.sv ====
// self-checking testbench for the dac waveform fifo front end
// assumes dwf_host_model drives the register port
`timescale 1ns/1ps
module test_dwf_front_end;
   import dwf_pkg::*;
   logic        core_clk   = 1'b0; // 40 mhz
   logic        rst_n      = 1'b0; // held low at start
   logic        point_tick = 1'b0; // playback start
   dwf_req_s    req;               // from host model
   logic        rd_valid;
   logic [31:0] rd_data;
   logic        dac_valid;
   dwf_cmd_s    dac_cmd;
   logic        point_done;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          cyc        = 0;    // timeout counter
   // full-fifo fill takes about 16400 cycles, the rest about 120
   localparam int CYC_LIMIT = 20000;
   logic [20:0] seen[$];           // {done, chan, code} per word sent
   always #12.5 core_clk = ~core_clk;
   dwf_front_end dwf_front_end_i (.core_clk(core_clk), .rst_n(rst_n), .req(req),
      .rd_valid(rd_valid), .rd_data(rd_data), .point_tick(point_tick),
      .dac_valid(dac_valid), .dac_cmd(dac_cmd), .point_done(point_done));
   dwf_host_model dwf_host_model_i (.core_clk(core_clk), .rd_valid(rd_valid),
      .rd_data(rd_data), .req(req));
   // ******************************
   // monitor and timeout
   // ******************************
   always @(posedge core_clk)
   begin
      if (dac_valid === 1'b1)
         seen.push_back({point_done, dac_cmd});
      cyc <= cyc + 1;
      // a hang ends the run as a failure
      if (cyc == CYC_LIMIT)
      begin
         fail_count++;
         stop_test();
      end
   end
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_dac(input logic [20:0] got, input logic [20:0] exp);
      chk_reg({11'h0, got}, {11'h0, exp});
   endtask
   // read and judge both the valid pulse and the data
   task automatic rd_chk(input logic w, input logic [7:0] a, input logic [31:0] e);
      logic        v;
      logic [31:0] d;
      dwf_host_model_i.rd(w, a, v, d);
      chk_reg({31'h0, v}, 32'h1);
      chk_reg(d, e);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ******************************
   // scenarios
   // ******************************
   task automatic t_reset();
      rd_chk(1'b1, 8'h54, 32'h1);
      rd_chk(1'b1, 8'h50, 32'h0);
      rd_chk(1'b1, 8'h58, 32'h2000);
   endtask
   task automatic t_push();
      dwf_host_model_i.wr(8'h50, 32'hFFF3_1234);
      dwf_host_model_i.wr(8'h50, 32'h0002_ABCD);
      rd_chk(1'b1, 8'h50, 32'h2);
      rd_chk(1'b1, 8'h50, 32'h2);
      dwf_host_model_i.wr(8'h58, 32'h5);
      rd_chk(1'b1, 8'h58, 32'h2000);
   endtask
   task automatic t_cpp();
      dwf_host_model_i.wr(8'h54, 32'h5);
      rd_chk(1'b1, 8'h54, 32'h1);
      dwf_host_model_i.wr(8'h54, 32'h0);
      rd_chk(1'b1, 8'h54, 32'h1);
      dwf_host_model_i.wr(8'h54, 32'h4);
      rd_chk(1'b1, 8'h54, 32'h4);
      dwf_host_model_i.wr(8'h54, 32'h2);
      rd_chk(1'b1, 8'h54, 32'h2);
   endtask
   // dma-window accesses must leave the i/o registers alone
   task automatic t_window();
      rd_chk(1'b0, 8'h50, 32'h0);
      dwf_host_model_i.wrw(1'b0, 8'h50, 32'h0001_0001);
      dwf_host_model_i.wrw(1'b0, 8'h54, 32'h4);
      rd_chk(1'b1, 8'h50, 32'h2);
      rd_chk(1'b1, 8'h54, 32'h2);
   endtask
   // fill to capacity plus one; the extra word must not overwrite the head
   task automatic t_full();
      for (int i = 0; i <= DWF_DEPTH; i++)
         dwf_host_model_i.wr(DWF_OFF_PUSH_LEVEL, 32'(i));
      rd_chk(1'b1, DWF_OFF_PUSH_LEVEL, DWF_CAPACITY);
      @(posedge core_clk);
      point_tick <= 1'b1;
      @(posedge core_clk);
      point_tick <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk_reg(32'(seen.size()), 32'h4);
      chk_dac(seen[2], 21'h00_0000);
      chk_dac(seen[3], 21'h10_0001);
      rd_chk(1'b1, DWF_OFF_PUSH_LEVEL, 32'h0000_1FFE);
   endtask
   // reset in mid-run clears the level and returns the point size to one
   task automatic t_rst_mid();
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(1'b1, DWF_OFF_PUSH_LEVEL, 32'h0);
      rd_chk(1'b1, DWF_OFF_CHAN_PER_PT, 32'h1);
   endtask
   // two words per point, then a tick with too few words left
   task automatic t_play();
      repeat (2)
      begin
         @(posedge core_clk);
         point_tick <= 1'b1;
         @(posedge core_clk);
         point_tick <= 1'b0;
         repeat (8) @(posedge core_clk);
      end
      chk_reg(32'(seen.size()), 32'h2);
      chk_dac(seen[0], 21'h03_1234);
      chk_dac(seen[1], 21'h12_ABCD);
      rd_chk(1'b1, 8'h50, 32'h0);
   endtask
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_push();
      t_cpp();
      t_window();
      t_play();
      t_full();
      t_rst_mid();
      stop_test();
   end
endmodule
